// file: eci_regs.svh
// register offsets, reset values and fixed counts of the encoder channel interface
`ifndef ECI_REGS_SVH
`define ECI_REGS_SVH
`define ECI_OFF_CTRL         8'h00
`define ECI_OFF_ENC_DIV      8'h04
`define ECI_OFF_ADC_DIV      8'h08
`define ECI_OFF_ADC_CTRL     8'h0c
`define ECI_OFF_ADC_DELAY    8'h10
`define ECI_OFF_ADC_HDR      8'h14
`define ECI_OFF_ADC_STROBE   8'h18
`define ECI_OFF_ADC_UTOS     8'h1c
`define ECI_OFF_COUNT        8'h20
`define ECI_OFF_PHASE        8'h24
`define ECI_OFF_POSITION     8'h28
`define ECI_OFF_PULSE_PERIOD 8'h2c
`define ECI_OFF_PULSE_CMD    8'h30
`define ECI_RST_CTRL         5'h00
`define ECI_RST_ENC_DIV      4'h3
`define ECI_RST_ADC_DIV      4'h3
`define ECI_RST_ADC_CTRL     32'h3fffc000
`define ECI_RST_ADC_DELAY    8'h00
`define ECI_RST_ADC_HDR      4'h0
`define ECI_RST_ADC_STROBE   24'h3fffc0
`define ECI_RST_ADC_UTOS     1'b0
`define ECI_RST_PULSE_PERIOD 16'h0018
`define ECI_STROBE_TOP       5'h17
`define ECI_SLOT_LAST        6'h1f
`define ECI_SAMPLE_BITS      5'h10
`define ECI_PCMD_DIR_BIT     31
`define ECI_QUAD_LAST        2'h3
`define ECI_QUAD_FIRST       2'h0
`endif

// file: eci_pkg.sv
// types shared by the encoder channel interface
`default_nettype none
package eci_pkg;
    typedef struct packed {
        logic pulse_quad;
        logic serial_encoder_enable;
        logic data_termination_disable;
        logic clock_output_select;
        logic sensor_request_output;
    } eci_ctrl_t;

    typedef struct packed {
        logic [3:0]  converter_clock_divider;
        logic [31:0] converter_control_word;
        logic [7:0]  converter_delay;
        logic [3:0]  converter_header_count;
        logic [23:0] converter_strobe_word;
        logic        converter_sign_convert;
    } eci_adc_cfg_t;

    typedef struct packed {
        logic [15:0] sin_v;
        logic [15:0] cos_v;
    } eci_sample_t;

    typedef enum logic [1:0] {ADC_IDLE, ADC_WAIT, ADC_SHIFT, ADC_CALC} eci_adc_state_t;
endpackage
`default_nettype wire

// file: eci_quad.sv
// x4 quadrature edge counter
`default_nettype none
module eci_quad #(
    parameter int CNT_W = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             sample,
    input  wire logic             a,
    input  wire logic             b,
    output logic      [CNT_W-1:0] count
);
    logic       prev_a_r;
    logic       prev_b_r;
    logic       step;
    logic       up;

    assign step = (a ^ prev_a_r) ^ (b ^ prev_b_r);
    assign up   = a ^ prev_b_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_a_r <= 1'b0;
            prev_b_r <= 1'b0;
        end else if (sample) begin
            prev_a_r <= a;
            prev_b_r <= b;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= '0;
        end else if (sample && step) begin
            count <= up ? count + 1'b1 : count - 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: eci_phase.sv
// iterative arctangent of one sine and cosine pair
`default_nettype none
module eci_phase #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         start,
    input  wire logic [W-1:0] sin_v,
    input  wire logic [W-1:0] cos_v,
    output logic      [W-1:0] phase,
    output logic              done
);
    logic signed [W+1:0] x_r;
    logic signed [W+1:0] y_r;
    logic        [4:0]   it_r;
    logic                busy_r;
    logic        [W-1:0] ang;

    // angle step per iteration, full turn is 2^16
    always_comb begin
        case (it_r)
            5'h00: ang = 16'h2000;
            5'h01: ang = 16'h12e4;
            5'h02: ang = 16'h09fb;
            5'h03: ang = 16'h0511;
            5'h04: ang = 16'h028b;
            5'h05: ang = 16'h0146;
            5'h06: ang = 16'h00a3;
            5'h07: ang = 16'h0051;
            5'h08: ang = 16'h0029;
            5'h09: ang = 16'h0014;
            5'h0a: ang = 16'h000a;
            5'h0b: ang = 16'h0005;
            5'h0c: ang = 16'h0003;
            5'h0d: ang = 16'h0001;
            5'h0e: ang = 16'h0001;
            default: ang = 16'h0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            x_r    <= '0;
            y_r    <= '0;
            phase  <= '0;
            it_r   <= '0;
            busy_r <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                busy_r <= 1'b1;
                it_r   <= '0;
                if (cos_v[W-1]) begin
                    x_r   <= -{{2{cos_v[W-1]}}, cos_v};
                    y_r   <= -{{2{sin_v[W-1]}}, sin_v};
                    phase <= {1'b1, {(W-1){1'b0}}};
                end else begin
                    x_r   <= {{2{cos_v[W-1]}}, cos_v};
                    y_r   <= {{2{sin_v[W-1]}}, sin_v};
                    phase <= '0;
                end
            end else if (busy_r) begin
                if (!y_r[W+1]) begin
                    x_r   <= x_r + (y_r >>> it_r);
                    y_r   <= y_r - (x_r >>> it_r);
                    phase <= phase + ang;
                end else begin
                    x_r   <= x_r - (y_r >>> it_r);
                    y_r   <= y_r + (x_r >>> it_r);
                    phase <= phase - ang;
                end
                it_r <= it_r + 1'b1;
                if (it_r == 5'(W - 1)) begin
                    busy_r <= 1'b0;
                    done   <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: eci_top.sv
// encoder channel interface: counter, converter reader, phase merge, flags, pulse output
//
// Notes on behaviour
// - quadrature counter gives four counts per cycle
// - servo event latches running count for software
// - servo event samples sine/cosine, arctangent gives phase
// - latched count and phase merge into position
// - divider zero samples inputs every clock
// - reset dividers three, control and strobe words
// - delay, header, sign convert reset to zero
// - sensor request bit drives output transistor
// - select bit picks serial or servo clock
// - termination only when enabled and not disabled
// - two pulse outputs, pulse/direction or quadrature
`default_nettype none
`include "eci_regs.svh"
module eci_top
    import eci_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        SERVO_CLK,
    input  wire logic        ENC_A,
    input  wire logic        ENC_B,
    input  wire logic        SER_CLK_IN,
    input  wire logic        ADC_SIN_SDI,
    input  wire logic        ADC_COS_SDI,
    output logic             ADC_SCLK,
    output logic             ADC_SDO,
    output logic             ADC_FRAME,
    output logic             SENSOR_REQ_ON,
    output logic             DIFF_CLK_OUT,
    output logic             DATA_TERM_EN,
    output logic             PULSE_OUT_A,
    output logic             PULSE_OUT_B
);
    eci_ctrl_t       ctrl_r;
    eci_adc_cfg_t    cfg_r;
    eci_adc_state_t  state_r;
    eci_sample_t     smp;
    logic [3:0]       enc_div_r;
    logic [3:0]       enc_cnt_r;
    logic             enc_tick;
    logic [4:0]       sync1_r;
    logic [4:0]       sync2_r;
    logic             servo_d_r;
    logic             servo_evt;
    logic [CNT_W-1:0] run_count;
    logic [CNT_W-1:0] count_hold_r;
    logic [7:0]       dly_r;
    logic [3:0]       div_cnt_r;
    logic [5:0]       slot_r;
    logic             sclk_r;
    logic [3:0]       hdr_left_r;
    logic [4:0]       bits_r;
    logic [15:0]      sin_sh_r;
    logic [15:0]      cos_sh_r;
    logic             calc_go_r;
    logic             strobe_bit;
    logic [4:0]       strobe_idx;
    logic [15:0]      phase_w;
    logic             phase_done;
    logic [15:0]      phase_r;
    logic [31:0]      position_r;
    logic [CNT_W-3:0] cyc;
    logic [CNT_W-3:0] cyc_adj;
    logic [15:0]      pulse_period_r;
    logic [15:0]      pulse_left_r;
    logic             pulse_dir_r;
    logic [15:0]      pcnt_r;
    logic             half_r;
    logic [1:0]       quad_r;
    logic             acc;
    logic             wr_pend_r;
    logic [7:0]       waddr_r;
    logic [31:0]      rd_mux;

    // pin inputs through two flip-flops
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
        end else begin
            sync1_r <= {ADC_COS_SDI, ADC_SIN_SDI, ENC_B, ENC_A, SERVO_CLK};
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            servo_d_r <= 1'b0;
        end else begin
            servo_d_r <= sync2_r[0];
        end
    end

    assign servo_evt = sync2_r[0] & ~servo_d_r;

    assign enc_tick = (enc_cnt_r == 4'h0);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            enc_cnt_r <= 4'h0;
        end else if (enc_tick) begin
            enc_cnt_r <= enc_div_r;
        end else begin
            enc_cnt_r <= enc_cnt_r - 1'b1;
        end
    end

    eci_quad #(
        .CNT_W (CNT_W)
    ) u_quad (
        .clk    (CLK),
        .rst_n  (RST_N),
        .sample (enc_tick),
        .a      (sync2_r[1]),
        .b      (sync2_r[2]),
        .count  (run_count)
    );

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            count_hold_r <= '0;
        end else if (servo_evt) begin
            count_hold_r <= run_count;
        end
    end

    assign strobe_idx = `ECI_STROBE_TOP - slot_r[4:0];
    assign strobe_bit = (slot_r[4:0] <= `ECI_STROBE_TOP) && cfg_r.converter_strobe_word[strobe_idx];

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_r    <= ADC_IDLE;
            dly_r      <= 8'h00;
            div_cnt_r  <= 4'h0;
            slot_r     <= 6'h00;
            sclk_r     <= 1'b0;
            hdr_left_r <= 4'h0;
            bits_r     <= 5'h00;
            sin_sh_r   <= 16'h0000;
            cos_sh_r   <= 16'h0000;
            calc_go_r  <= 1'b0;
        end else begin
            calc_go_r <= 1'b0;
            case (state_r)
                ADC_IDLE: begin
                    if (servo_evt) begin
                        dly_r   <= cfg_r.converter_delay;
                        state_r <= ADC_WAIT;
                    end
                end
                ADC_WAIT: begin
                    if (dly_r == 8'h00) begin
                        state_r    <= ADC_SHIFT;
                        slot_r     <= 6'h00;
                        div_cnt_r  <= cfg_r.converter_clock_divider;
                        sclk_r     <= 1'b0;
                        hdr_left_r <= cfg_r.converter_header_count;
                        bits_r     <= 5'h00;
                        sin_sh_r   <= 16'h0000;
                        cos_sh_r   <= 16'h0000;
                    end else begin
                        dly_r <= dly_r - 1'b1;
                    end
                end
                ADC_SHIFT: begin
                    if (div_cnt_r != 4'h0) begin
                        div_cnt_r <= div_cnt_r - 1'b1;
                    end else begin
                        div_cnt_r <= cfg_r.converter_clock_divider;
                        sclk_r    <= ~sclk_r;
                        if (!sclk_r && strobe_bit) begin
                            if (hdr_left_r != 4'h0) begin
                                hdr_left_r <= hdr_left_r - 1'b1;
                            end else if (bits_r < `ECI_SAMPLE_BITS) begin
                                sin_sh_r <= {sin_sh_r[14:0], sync2_r[3]};
                                cos_sh_r <= {cos_sh_r[14:0], sync2_r[4]};
                                bits_r   <= bits_r + 1'b1;
                            end
                        end
                        if (sclk_r) begin
                            if (slot_r == `ECI_SLOT_LAST) begin
                                state_r <= ADC_CALC;
                            end else begin
                                slot_r <= slot_r + 1'b1;
                            end
                        end
                    end
                end
                ADC_CALC: begin
                    calc_go_r <= 1'b1;
                    state_r   <= ADC_IDLE;
                end
                default: begin
                    state_r <= ADC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ADC_SCLK  <= 1'b0;
            ADC_SDO   <= 1'b0;
            ADC_FRAME <= 1'b0;
        end else begin
            ADC_SCLK  <= (state_r == ADC_SHIFT) && sclk_r;
            ADC_SDO   <= (state_r == ADC_SHIFT) && cfg_r.converter_control_word[~slot_r[4:0]];
            ADC_FRAME <= (state_r == ADC_SHIFT) && strobe_bit;
        end
    end

    // unsigned samples become signed by flipping the top bit
    assign smp.sin_v = sin_sh_r ^ {cfg_r.converter_sign_convert, 15'h0000};
    assign smp.cos_v = cos_sh_r ^ {cfg_r.converter_sign_convert, 15'h0000};

    eci_phase #(
        .W (16)
    ) u_phase (
        .clk   (CLK),
        .rst_n (RST_N),
        .start (calc_go_r),
        .sin_v (smp.sin_v),
        .cos_v (smp.cos_v),
        .phase (phase_w),
        .done  (phase_done)
    );

    assign cyc = count_hold_r[CNT_W-1:2];

    always_comb begin
        cyc_adj = cyc;
        if (count_hold_r[1:0] == `ECI_QUAD_LAST && phase_w[15:14] == `ECI_QUAD_FIRST) begin
            cyc_adj = cyc + 1'b1;
        end else if (count_hold_r[1:0] == `ECI_QUAD_FIRST && phase_w[15:14] == `ECI_QUAD_LAST) begin
            cyc_adj = cyc - 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            phase_r    <= 16'h0000;
            position_r <= 32'h00000000;
        end else if (phase_done) begin
            phase_r    <= phase_w;
            position_r <= {cyc_adj[15:0], phase_w};
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            SENSOR_REQ_ON <= 1'b0;
            DIFF_CLK_OUT  <= 1'b0;
            DATA_TERM_EN  <= 1'b0;
        end else begin
            SENSOR_REQ_ON <= ctrl_r.sensor_request_output;
            DIFF_CLK_OUT  <= ctrl_r.clock_output_select ? sync2_r[0] : SER_CLK_IN;
            DATA_TERM_EN  <= ~ctrl_r.data_termination_disable & ctrl_r.serial_encoder_enable;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pcnt_r       <= 16'h0000;
            half_r       <= 1'b0;
            quad_r       <= 2'h0;
            pulse_left_r <= 16'h0000;
            pulse_dir_r  <= 1'b0;
        end else if (wr_pend_r && waddr_r == `ECI_OFF_PULSE_CMD) begin
            pulse_left_r <= HWDATA[15:0];
            pulse_dir_r  <= HWDATA[`ECI_PCMD_DIR_BIT];
            pcnt_r       <= 16'h0000;
            half_r       <= 1'b0;
        end else if (pulse_left_r == 16'h0000) begin
            half_r <= 1'b0;
            pcnt_r <= 16'h0000;
        end else if (pcnt_r != 16'h0000) begin
            pcnt_r <= pcnt_r - 1'b1;
        end else begin
            pcnt_r <= pulse_period_r;
            half_r <= ~half_r;
            if (half_r) begin
                pulse_left_r <= pulse_left_r - 1'b1;
                quad_r       <= pulse_dir_r ? {quad_r[0], ~quad_r[1]} : {~quad_r[0], quad_r[1]};
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PULSE_OUT_A <= 1'b0;
            PULSE_OUT_B <= 1'b0;
        end else if (ctrl_r.pulse_quad) begin
            PULSE_OUT_A <= quad_r[1];
            PULSE_OUT_B <= quad_r[0];
        end else begin
            PULSE_OUT_A <= half_r;
            PULSE_OUT_B <= pulse_dir_r;
        end
    end

    // bus slave, zero wait states
    assign acc = HSEL & HTRANS[1] & HREADY;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wr_pend_r <= 1'b0;
            waddr_r   <= 8'h00;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            wr_pend_r <= acc & HWRITE;
            waddr_r   <= HADDR[7:0];
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    always_comb begin
        case (HADDR[7:0])
            `ECI_OFF_CTRL:         rd_mux = {27'h0000000, ctrl_r};
            `ECI_OFF_ENC_DIV:      rd_mux = {28'h0000000, enc_div_r};
            `ECI_OFF_ADC_DIV:      rd_mux = {28'h0000000, cfg_r.converter_clock_divider};
            `ECI_OFF_ADC_CTRL:     rd_mux = cfg_r.converter_control_word;
            `ECI_OFF_ADC_DELAY:    rd_mux = {24'h000000, cfg_r.converter_delay};
            `ECI_OFF_ADC_HDR:      rd_mux = {28'h0000000, cfg_r.converter_header_count};
            `ECI_OFF_ADC_STROBE:   rd_mux = {8'h00, cfg_r.converter_strobe_word};
            `ECI_OFF_ADC_UTOS:     rd_mux = {31'h00000000, cfg_r.converter_sign_convert};
            `ECI_OFF_COUNT:        rd_mux = 32'(count_hold_r);
            `ECI_OFF_PHASE:        rd_mux = {16'h0000, phase_r};
            `ECI_OFF_POSITION:     rd_mux = position_r;
            `ECI_OFF_PULSE_PERIOD: rd_mux = {16'h0000, pulse_period_r};
            `ECI_OFF_PULSE_CMD:    rd_mux = {pulse_dir_r, 15'h0000, pulse_left_r};
            default:               rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            HRDATA <= 32'h00000000;
        end else if (acc && !HWRITE) begin
            HRDATA <= rd_mux;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl_r                        <= `ECI_RST_CTRL;
            enc_div_r                     <= `ECI_RST_ENC_DIV;
            cfg_r.converter_clock_divider <= `ECI_RST_ADC_DIV;
            cfg_r.converter_control_word  <= `ECI_RST_ADC_CTRL;
            cfg_r.converter_delay         <= `ECI_RST_ADC_DELAY;
            cfg_r.converter_header_count  <= `ECI_RST_ADC_HDR;
            cfg_r.converter_strobe_word   <= `ECI_RST_ADC_STROBE;
            cfg_r.converter_sign_convert  <= `ECI_RST_ADC_UTOS;
            pulse_period_r                <= `ECI_RST_PULSE_PERIOD;
        end else if (wr_pend_r) begin
            case (waddr_r)
                `ECI_OFF_CTRL:         ctrl_r <= HWDATA[4:0];
                `ECI_OFF_ENC_DIV:      enc_div_r <= HWDATA[3:0];
                `ECI_OFF_ADC_DIV:      cfg_r.converter_clock_divider <= HWDATA[3:0];
                `ECI_OFF_ADC_CTRL:     cfg_r.converter_control_word <= HWDATA;
                `ECI_OFF_ADC_DELAY:    cfg_r.converter_delay <= HWDATA[7:0];
                `ECI_OFF_ADC_HDR:      cfg_r.converter_header_count <= HWDATA[3:0];
                `ECI_OFF_ADC_STROBE:   cfg_r.converter_strobe_word <= HWDATA[23:0];
                `ECI_OFF_ADC_UTOS:     cfg_r.converter_sign_convert <= HWDATA[0];
                `ECI_OFF_PULSE_PERIOD: pulse_period_r <= HWDATA[15:0];
                default: begin
                end
            endcase
        end
    end

    logic unused_ok;
    assign unused_ok = ^{HADDR[31:8], HSIZE};
endmodule
`default_nettype wire

// file: eci_top_properties.sv
// port checker for the encoder channel interface
`default_nettype none
module eci_top_properties (
    input wire logic        CLK,
    input wire logic        RST_N,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        SER_CLK_IN,
    input wire logic        SENSOR_REQ_ON,
    input wire logic        DIFF_CLK_OUT,
    input wire logic        DATA_TERM_EN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       wr_ph_r;
    logic [4:0] ctl_r;
    wire        acc = HSEL & HTRANS[1] & HREADY;
    wire        rd0 = acc & ~HWRITE & (HADDR[7:0] == 8'h00);
    // shadow of the control register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            wr_ph_r <= 1'b0;
            ctl_r   <= 5'h00;
        end else begin
            wr_ph_r <= acc & HWRITE & (HADDR[7:0] == 8'h00);
            if (wr_ph_r) begin
                ctl_r <= HWDATA[4:0];
            end
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    AST_READY_HIGH: assert property (HREADYOUT) else $error("hreadyout low");
    AST_RESP_OKAY: assert property (!HRESP) else $error("hresp not okay");
    AST_SENSOR_REQ: assert property (SENSOR_REQ_ON == $past(ctl_r[0])) else $error("sensor request wrong");
    AST_TERM_EN: assert property (DATA_TERM_EN == ($past(ctl_r[3]) & ~$past(ctl_r[2])))
        else $error("termination wrong");
    AST_CLK_SEL: assert property (($past(RST_N) && !$past(ctl_r[1])) |-> DIFF_CLK_OUT == $past(SER_CLK_IN))
        else $error("clock pair not serial clock");
    AST_RD_HOLD: assert property (($past(RST_N) && !$past(acc & ~HWRITE)) |-> $stable(HRDATA))
        else $error("read data moved");
    AST_CTRL_RD: assert property ((rd0 && !wr_ph_r) |=> HRDATA == {27'h0, $past(ctl_r)})
        else $error("control readback wrong");
    AST_UNMAPPED: assert property ((acc && !HWRITE && HADDR[7:0] >= 8'h34) |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind eci_top eci_top_properties u_props (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SER_CLK_IN(SER_CLK_IN), .SENSOR_REQ_ON(SENSOR_REQ_ON),
    .DIFF_CLK_OUT(DIFF_CLK_OUT), .DATA_TERM_EN(DATA_TERM_EN));
`default_nettype wire

// file: eci_enc_model.sv
// encoder and converter model at the far side
`default_nettype none
module eci_enc_model (
    input  wire logic clk,
    input  wire logic step,
    input  wire logic dir_dn,
    input  wire logic sclk,
    output logic      enc_a,
    output logic      enc_b,
    output logic      sin_sdi,
    output logic      cos_sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_r = 2'h0;
    initial sin_sdi = 1'b0;
    initial cos_sdi = 1'b1;
    // a leads b going up: 00 10 11 01
    always @(posedge clk) begin
        if (step) begin
            ph_r <= dir_dn ? ph_r - 2'h1 : ph_r + 2'h1;
        end
    end
    assign enc_a = ph_r[0] ^ ph_r[1];
    assign enc_b = ph_r[1];
    // converter data changes every bit
    always @(posedge sclk) begin
        sin_sdi <= ~sin_sdi;
        cos_sdi <= sin_sdi;
    end
endmodule
`default_nettype wire

// file: tb_encoder_channel_interface.sv
// self-checking bench for the encoder channel interface
`default_nettype none
module tb_encoder_channel_interface;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  adr;
        logic [31:0] val;
    } eci_row_t;
    logic        CLK = 0, RST_N = 0, HSEL = 0, HWRITE = 0, SERVO_CLK = 0, SER_CLK_IN = 0, step = 0, dn = 0;
    logic [1:0]  HTRANS = 0;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA, rd;
    logic        HREADYOUT, HRESP, ENC_A, ENC_B, SIN_SDI, COS_SDI, ADC_SCLK, ADC_SDO, ADC_FRAME, pa, pb, sc;
    logic        SENSOR_REQ_ON, DIFF_CLK_OUT, DATA_TERM_EN, PULSE_OUT_A, PULSE_OUT_B;
    int          err_count = 0, comparisons = 0, a_rise = 0, ab_chg = 0, n0, n_sck = 0;
    eci_row_t    rows [11] = '{'{8'h00, 32'h0}, '{8'h04, 32'h3}, '{8'h08, 32'h3}, '{8'h0c, 32'h3fffc000},
        '{8'h10, 32'h0}, '{8'h14, 32'h0}, '{8'h18, 32'h3fffc0}, '{8'h1c, 32'h0}, '{8'h20, 32'h0},
        '{8'h2c, 32'h18}, '{8'h40, 32'h0}};
    always #10 CLK = ~CLK;
    always @(posedge CLK) begin
        SER_CLK_IN <= ~SER_CLK_IN;
        pa <= PULSE_OUT_A;
        pb <= PULSE_OUT_B;
        a_rise <= a_rise + int'(PULSE_OUT_A && !pa);
        ab_chg <= ab_chg + int'(PULSE_OUT_A !== pa) + int'(PULSE_OUT_B !== pb);
        sc <= ADC_SCLK;
        n_sck <= n_sck + int'(ADC_SCLK && !sc);
    end
    eci_top dut (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .SERVO_CLK(SERVO_CLK), .ENC_A(ENC_A), .ENC_B(ENC_B), .SER_CLK_IN(SER_CLK_IN),
        .ADC_SIN_SDI(SIN_SDI), .ADC_COS_SDI(COS_SDI), .ADC_SCLK(ADC_SCLK), .ADC_SDO(ADC_SDO),
        .ADC_FRAME(ADC_FRAME), .SENSOR_REQ_ON(SENSOR_REQ_ON), .DIFF_CLK_OUT(DIFF_CLK_OUT),
        .DATA_TERM_EN(DATA_TERM_EN), .PULSE_OUT_A(PULSE_OUT_A), .PULSE_OUT_B(PULSE_OUT_B));
    eci_enc_model u_enc (.clk(CLK), .step(step), .dir_dn(dn), .sclk(ADC_SCLK), .enc_a(ENC_A),
        .enc_b(ENC_B), .sin_sdi(SIN_SDI), .cos_sdi(COS_SDI));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
    endtask
    task automatic steps(input int n, input logic d);
        repeat (n) begin
            step <= 1'b1;
            dn <= d;
            @(posedge CLK);
            step <= 1'b0;
            @(posedge CLK);
        end
        repeat (8) @(posedge CLK);
    endtask
    task automatic servo(input logic lvl);
        SERVO_CLK <= lvl;
        repeat (6) @(posedge CLK);
    endtask
    task automatic final_report();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        foreach (rows[i]) begin
            bus(1'b0, rows[i].adr, 32'h0);
            chk(rd, rows[i].val);
        end
        for (int v = 0; v < 16; v++) begin
            bus(1'b1, 8'h00, v);
            bus(1'b0, 8'h00, 32'h0);
            chk(rd, v);
            chk(SENSOR_REQ_ON, v[0]);
            chk(DATA_TERM_EN, v[3] & ~v[2]);
        end
        servo(1'b1);
        chk(DIFF_CLK_OUT, 1'b1);
        servo(1'b0);
        chk(DIFF_CLK_OUT, 1'b0);
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h0);
        steps(8, 1'b0);
        servo(1'b1);
        servo(1'b0);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h8);
        steps(3, 1'b1);
        servo(1'b1);
        servo(1'b0);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h5);
        steps(2, 1'b0);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h5);
        servo(1'b1);
        servo(1'b0);
        bus(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h7);
        bus(1'b1, 8'h2c, 32'h1);
        n0 = a_rise;
        bus(1'b1, 8'h30, 32'h80000003);
        repeat (40) @(posedge CLK);
        chk(a_rise - n0, 32'h3);
        chk(PULSE_OUT_B, 1'b1);
        bus(1'b1, 8'h00, 32'h10);
        repeat (4) @(posedge CLK);
        n0 = ab_chg;
        bus(1'b1, 8'h30, 32'h4);
        repeat (60) @(posedge CLK);
        chk(ab_chg - n0, 32'h4);
        bus(1'b0, 8'h30, 32'h0);
        chk(rd & 32'hffff, 32'h0);
        repeat (300) @(posedge CLK);
        bus(1'b0, 8'h24, 32'h0);
        chk(16'(rd[15:0] + 16'h0040 - 16'h6000) < 16'h0080, 1'b1);
        bus(1'b0, 8'h28, 32'h0);
        chk(rd[31:16], 32'h1);
        chk(n_sck, 32'h20);
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        final_report();
    end
    initial begin
        repeat (30000) @(posedge CLK);
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
